// >>> hdl/pfs_sequencer.sv
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module pfs_sequencer #(
  parameter int CYC_PER_MS = pfs_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // comparator flags, already synchronous
  input wire logic temp_over_100,
  input wire logic temp_over_125,
  input wire logic temp_over_155,
  input wire logic gate_drive_supply_ok,
  input wire logic common_supply_ok,
  input wire logic short_to_gnd,
  input wire logic short_to_stage_supply,
  input wire logic overload_detect,
  input wire logic overcurrent_detect,
  // controller reset pin
  input wire logic reset_in_n,
  // open-drain status pins
  input wire logic shutdown_fault_n_i,
  output logic shutdown_fault_n_o,
  output logic shutdown_fault_n_oe_n,
  input wire logic temp_warn_low_n_i,
  output logic temp_warn_low_n_o,
  output logic temp_warn_low_n_oe_n,
  input wire logic temp_warn_high_n_i,
  output logic temp_warn_high_n_o,
  output logic temp_warn_high_n_oe_n,
  input wire logic temp_warn_single_n_i,
  output logic temp_warn_single_n_o,
  output logic temp_warn_single_n_oe_n,
  // power stage control
  output logic [3:0] bridge_hiz,
  output logic [3:0] bridge_pulldown,
  output logic ready
);

  pfs_tick_if tb();

  pfs_timebase #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_timebase (
    .aclk(aclk),
    .aresetn(aresetn),
    .tb(tb)
  );

  // open-drain pins only ever pull low
  assign shutdown_fault_n_o = 1'b0;
  assign temp_warn_low_n_o = 1'b0;
  assign temp_warn_high_n_o = 1'b0;
  assign temp_warn_single_n_o = 1'b0;

  // register file
  pfs_pkg::pfs_mode_t mode;
  pfs_pkg::pfs_mode_t next_mode;
  logic variant_two;
  logic next_variant_two;
  logic [7:0] check_step_ms;
  logic [7:0] next_check_step_ms;
  logic [7:0] start_ms;
  logic [7:0] next_start_ms;

  // bus slave state
  logic aw_hold;
  logic next_aw_hold;
  logic w_hold;
  logic next_w_hold;
  logic [7:0] wr_addr;
  logic [7:0] next_wr_addr;
  logic [31:0] wr_data;
  logic [31:0] next_wr_data;
  logic [3:0] wr_strb;
  logic [3:0] next_wr_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // sequencer state
  pfs_pkg::pfs_state_t state;
  pfs_pkg::pfs_state_t next_state;
  logic [7:0] ms_left;
  logic [7:0] next_ms_left;
  logic checked;
  logic next_checked;
  logic overtemp_error_latch;
  logic next_ote;
  logic ovl;
  logic next_ovl;
  logic reset_q;
  logic next_restart;
  logic restart;

  // registered pin values
  logic next_sd_low;
  logic next_warn_low;
  logic next_warn_high;
  logic next_warn_single;
  logic [3:0] next_hiz;
  logic [3:0] next_pulldown;
  logic next_ready;

  logic supplies_ok;
  logic checking;
  logic reset_rise;

  function automatic logic [7:0] pfs_ofs(input logic [31:0] addr);
    pfs_ofs = addr[7:0];
  endfunction : pfs_ofs

  function automatic logic pfs_mapped(input logic [31:0] addr);
    pfs_mapped = (addr[31:8] == 24'h000000) && (addr[1:0] == 2'h0) &&
                 (addr[7:0] <= pfs_pkg::STATUS_OFS);
  endfunction : pfs_mapped

  assign supplies_ok = gate_drive_supply_ok && common_supply_ok;
  assign checking = (state == pfs_pkg::PFS_CHECK_GND) ||
                    (state == pfs_pkg::PFS_CHECK_SUPPLY) ||
                    (state == pfs_pkg::PFS_SHORT_HOLD);
  assign reset_rise = reset_in_n && !reset_q;
  assign tb.restart = restart;

  // write path: address and data taken in either order
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_mode = mode;
    next_variant_two = variant_two;
    next_check_step_ms = check_step_ms;
    next_start_ms = start_ms;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_wr_addr = pfs_ofs(s_axi_awaddr);
      if (!pfs_mapped(s_axi_awaddr)) begin
        next_wr_addr = 8'hFF;
      end
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_wr_data = s_axi_wdata;
      next_wr_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_hold && w_hold && !s_axi_bvalid) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = pfs_pkg::RESP_OKAY;
      if (wr_strb[0]) begin
        unique case (wr_addr)
          pfs_pkg::CONFIG_OFS: begin
            next_mode = pfs_pkg::pfs_mode_t'(
              wr_data[pfs_pkg::CFG_MODE_LSB +: 2]);
            next_variant_two = wr_data[pfs_pkg::CFG_VARIANT_BIT];
          end
          pfs_pkg::CHECK_OFS: next_check_step_ms = wr_data[7:0];
          pfs_pkg::START_OFS: next_start_ms = wr_data[7:0];
          default: ;
        endcase
      end
      if (wr_addr == 8'hFF) begin
        next_bresp = pfs_pkg::RESP_SLVERR;
      end
    end
  end

  // read path: one outstanding read, data registered
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = 32'h00000000;
      next_rresp = pfs_pkg::RESP_OKAY;
      if (!pfs_mapped(s_axi_araddr)) begin
        next_rresp = pfs_pkg::RESP_SLVERR;
      end else begin
        unique case (pfs_ofs(s_axi_araddr))
          pfs_pkg::CONFIG_OFS: begin
            next_rdata[pfs_pkg::CFG_MODE_LSB +: 2] = mode;
            next_rdata[pfs_pkg::CFG_VARIANT_BIT] = variant_two;
          end
          pfs_pkg::CHECK_OFS: next_rdata[7:0] = check_step_ms;
          pfs_pkg::START_OFS: next_rdata[7:0] = start_ms;
          pfs_pkg::STATUS_OFS: begin
            next_rdata[pfs_pkg::ST_STATE_LSB +: 3] = state;
            next_rdata[pfs_pkg::ST_CHECKED_BIT] = checked;
            next_rdata[pfs_pkg::ST_OTE_BIT] = overtemp_error_latch;
            next_rdata[pfs_pkg::ST_OVL_BIT] = ovl;
            next_rdata[pfs_pkg::ST_READY_BIT] = ready;
            next_rdata[pfs_pkg::ST_RESET_IN_BIT] = reset_q;
          end
          default: ;
        endcase
      end
    end
  end

  // start-up sequencer and fault latches
  always_comb begin
    next_state = state;
    next_ms_left = ms_left;
    next_checked = checked;
    next_restart = 1'b0;
    next_ote = overtemp_error_latch;
    next_ovl = ovl;
    if (tb.tick && ms_left != 8'h00) begin
      next_ms_left = ms_left - 8'h01;
    end
    unique case (state)
      pfs_pkg::PFS_POWER_WAIT: begin
        if (supplies_ok) begin
          next_restart = 1'b1;
          if (!checked && mode != pfs_pkg::PFS_SINGLE_ENDED) begin
            next_state = pfs_pkg::PFS_CHECK_GND;
            next_ms_left = check_step_ms;
          end else begin
            next_state = pfs_pkg::PFS_STARTUP;
            next_ms_left = start_ms;
          end
        end
      end
      pfs_pkg::PFS_CHECK_GND: begin
        if (short_to_gnd) begin
          next_state = pfs_pkg::PFS_SHORT_HOLD;
        end else if (ms_left == 8'h00 ||
                     (tb.tick && ms_left == 8'h01)) begin
          next_state = pfs_pkg::PFS_CHECK_SUPPLY;
          next_ms_left = check_step_ms;
          next_restart = 1'b1;
        end
      end
      pfs_pkg::PFS_CHECK_SUPPLY: begin
        if (short_to_stage_supply) begin
          next_state = pfs_pkg::PFS_SHORT_HOLD;
        end else if (ms_left == 8'h00 ||
                     (tb.tick && ms_left == 8'h01)) begin
          next_state = pfs_pkg::PFS_STARTUP;
          next_checked = 1'b1;
          next_ms_left = start_ms;
          next_restart = 1'b1;
        end
      end
      pfs_pkg::PFS_SHORT_HOLD: begin
        if (!short_to_gnd && !short_to_stage_supply) begin
          next_state = pfs_pkg::PFS_STARTUP;
          next_checked = 1'b1;
          next_ms_left = start_ms;
          next_restart = 1'b1;
        end
      end
      pfs_pkg::PFS_STARTUP: begin
        if (!reset_in_n) begin
          next_ms_left = start_ms;
          next_restart = 1'b1;
        end else if (ms_left == 8'h00 ||
                     (tb.tick && ms_left == 8'h01)) begin
          next_state = pfs_pkg::PFS_RUN;
        end
      end
      pfs_pkg::PFS_RUN: begin
        if (!reset_in_n) begin
          next_state = pfs_pkg::PFS_STARTUP;
          next_ms_left = start_ms;
          next_restart = 1'b1;
        end
      end
      default: next_state = pfs_pkg::PFS_POWER_WAIT;
    endcase
    // checked survives supply dips; only a common-supply loss reruns it
    if (!supplies_ok) begin
      next_state = pfs_pkg::PFS_POWER_WAIT;
    end
    if (!common_supply_ok) begin
      next_checked = 1'b0;
      next_ovl = 1'b0;
    end else begin
      if (reset_rise && !checking) begin
        next_ovl = 1'b0;
      end
      if (overload_detect) begin
        next_ovl = 1'b1;
      end
    end
    if (!reset_in_n && !checking) begin
      next_ote = 1'b0;
    end
    if (temp_over_155) begin
      next_ote = 1'b1;
    end
  end

  // pin values, registered one cycle after their cause
  always_comb begin
    next_sd_low = checking || !supplies_ok || overtemp_error_latch || ovl;
    if (!reset_in_n && !checking) begin
      next_sd_low = 1'b0;
    end
    next_hiz = 4'hF;
    if (state == pfs_pkg::PFS_RUN && supplies_ok && !overtemp_error_latch && !ovl &&
        reset_in_n) begin
      next_hiz = 4'h0;
    end
    next_pulldown = 4'h0;
    if (!reset_in_n && !checking && supplies_ok &&
        mode != pfs_pkg::PFS_SINGLE_ENDED) begin
      next_pulldown = 4'hF;
    end
    next_warn_low = !variant_two && temp_over_100;
    next_warn_high = !variant_two && temp_over_125;
    next_warn_single = variant_two && temp_over_125;
    next_ready = (next_hiz == 4'h0) && !overcurrent_detect;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= pfs_pkg::pfs_mode_t'(pfs_pkg::MODE_RST);
      variant_two <= pfs_pkg::VARIANT_RST;
      check_step_ms <= pfs_pkg::CHECK_STEP_MS_RST;
      start_ms <= pfs_pkg::START_MS_RST;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
      state <= pfs_pkg::PFS_POWER_WAIT;
      ms_left <= 8'h00;
      checked <= 1'b0;
      overtemp_error_latch <= 1'b0;
      ovl <= 1'b0;
      reset_q <= 1'b1; // idle pin level, so no false rise after reset
      restart <= 1'b0;
      shutdown_fault_n_oe_n <= 1'b1;
      temp_warn_low_n_oe_n <= 1'b1;
      temp_warn_high_n_oe_n <= 1'b1;
      temp_warn_single_n_oe_n <= 1'b1;
      bridge_hiz <= 4'hF;
      bridge_pulldown <= 4'h0;
      ready <= 1'b0;
    end else begin
      mode <= next_mode;
      variant_two <= next_variant_two;
      check_step_ms <= next_check_step_ms;
      start_ms <= next_start_ms;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      s_axi_awready <= !next_aw_hold;
      s_axi_wready <= !next_w_hold;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      state <= next_state;
      ms_left <= next_ms_left;
      checked <= next_checked;
      overtemp_error_latch <= next_ote;
      ovl <= next_ovl;
      reset_q <= reset_in_n;
      restart <= next_restart;
      shutdown_fault_n_oe_n <= !next_sd_low;
      temp_warn_low_n_oe_n <= !next_warn_low;
      temp_warn_high_n_oe_n <= !next_warn_high;
      temp_warn_single_n_oe_n <= !next_warn_single;
      bridge_hiz <= next_hiz;
      bridge_pulldown <= next_pulldown;
      ready <= next_ready;
    end
  end

endmodule : pfs_sequencer

// >>> hdl/pfs_pkg.sv
package pfs_pkg;

  // clock and timebase
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // short check scales with filter capacitance: under 15 ms per uF
  localparam int CHECK_MS_PER_UF = 15;
  localparam logic [7:0] CHECK_STEP_MS_RST = 8'(CHECK_MS_PER_UF / 2 + 1);
  localparam logic [7:0] START_MS_RST = 8'h01;

  // register byte offsets
  localparam logic [7:0] CONFIG_OFS = 8'h00;
  localparam logic [7:0] CHECK_OFS = 8'h04;
  localparam logic [7:0] START_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;

  // config fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_VARIANT_BIT = 2;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic VARIANT_RST = 1'b0;

  // status fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_CHECKED_BIT = 4;
  localparam int ST_OTE_BIT = 5;
  localparam int ST_OVL_BIT = 6;
  localparam int ST_READY_BIT = 7;
  localparam int ST_RESET_IN_BIT = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PFS_BRIDGE_LOAD,
    PFS_PARALLEL_BRIDGE,
    PFS_SINGLE_ENDED,
    PFS_MODE_SPARE
  } pfs_mode_t;

  typedef enum logic [2:0] {
    PFS_POWER_WAIT,
    PFS_CHECK_GND,
    PFS_CHECK_SUPPLY,
    PFS_SHORT_HOLD,
    PFS_STARTUP,
    PFS_RUN
  } pfs_state_t;

endpackage : pfs_pkg

// >>> hdl/pfs_tick_if.sv
`timescale 1ns/1ps
interface pfs_tick_if;
  logic restart;
  logic tick;
  modport user (output restart, input tick);
  modport timer (input restart, output tick);
endinterface : pfs_tick_if

// >>> hdl/pfs_timebase.sv
`timescale 1ns/1ps
module pfs_timebase #(
  parameter int CYC_PER_MS = pfs_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // millisecond tick toward the sequencer
  pfs_tick_if.timer tb
);

  logic [31:0] count;
  logic [31:0] next_count;
  logic tick;
  logic next_tick;

  // restart realigns the first tick to a whole millisecond
  always_comb begin
    next_tick = 1'b0;
    next_count = count + 32'h00000001;
    if (tb.restart) begin
      next_count = 32'h00000000;
    end else if (count >= 32'(CYC_PER_MS - 1)) begin
      next_count = 32'h00000000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 32'h00000000;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

  assign tb.tick = tick;

endmodule : pfs_timebase

// >>> bench/pfs_seq_props.sv
`timescale 1ns/1ps
module pfs_seq_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // flags and controller pin
  input wire logic reset_in_n,
  input wire logic temp_over_100,
  input wire logic temp_over_125,
  input wire logic temp_over_155,
  input wire logic gate_drive_supply_ok,
  input wire logic common_supply_ok,
  input wire logic overload_detect,
  input wire logic overcurrent_detect,
  // status pins and power stage
  input wire logic shutdown_fault_n_o,
  input wire logic shutdown_fault_n_oe_n,
  input wire logic temp_warn_low_n_o,
  input wire logic temp_warn_low_n_oe_n,
  input wire logic temp_warn_high_n_oe_n,
  input wire logic temp_warn_single_n_oe_n,
  input wire logic [3:0] bridge_hiz,
  input wire logic [3:0] bridge_pulldown,
  input wire logic ready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  hiz_reset_a: assert property (!reset_in_n |=> bridge_hiz == 4'hF)
    else $error("bridges switching during reset");
  uv_off_a: assert property ((!gate_drive_supply_ok || !common_supply_ok)
    |-> ##[1:2] bridge_hiz == 4'hF) else $error("bridges on at low supply");
  uv_sd_a: assert property ((reset_in_n && !common_supply_ok)[*2]
    |=> !shutdown_fault_n_oe_n) else $error("no shutdown at low supply");
  ote_off_a: assert property (temp_over_155 |-> ##2 bridge_hiz == 4'hF)
    else $error("bridges on when overheated");
  ote_hold_a: assert property (temp_over_155 ##1 reset_in_n[*6]
    |=> bridge_hiz == 4'hF && !shutdown_fault_n_oe_n)
    else $error("overtemp shutdown not latched");
  ovl_off_a: assert property (overload_detect |-> ##2 bridge_hiz == 4'hF)
    else $error("bridges on after overload");
  warn_idle_a: assert property ((!temp_over_100 && !temp_over_125)[*2]
    |=> temp_warn_low_n_oe_n && temp_warn_high_n_oe_n
        && temp_warn_single_n_oe_n) else $error("warning without heat");
  warn_hot_a: assert property (temp_over_125[*2]
    |=> !temp_warn_high_n_oe_n || !temp_warn_single_n_oe_n)
    else $error("no warning when hot");
  ready_oc_a: assert property (overcurrent_detect |=> !ready)
    else $error("ready high on overcurrent");
  pull_off_a: assert property (reset_in_n[*2] |=> bridge_pulldown == 4'h0)
    else $error("pulldown on out of reset");
  od_low_a: assert property (!shutdown_fault_n_o && !temp_warn_low_n_o)
    else $error("open drain pin drives high");

  cover property (temp_over_155 ##2 bridge_hiz == 4'hF);
  cover property (!reset_in_n ##1 reset_in_n);
  cover property ($fell(ready));
endmodule : pfs_seq_props

bind pfs_sequencer pfs_seq_props u_props (.aclk, .aresetn, .reset_in_n,
  .temp_over_100, .temp_over_125, .temp_over_155, .gate_drive_supply_ok,
  .common_supply_ok, .overload_detect, .overcurrent_detect,
  .shutdown_fault_n_o, .shutdown_fault_n_oe_n, .temp_warn_low_n_o,
  .temp_warn_low_n_oe_n, .temp_warn_high_n_oe_n, .temp_warn_single_n_oe_n,
  .bridge_hiz, .bridge_pulldown, .ready);

// >>> bench/pfs_ctrl_model.sv
`timescale 1ns/1ps
module pfs_ctrl_model #(
  parameter int WAIT_CYC = 40
) (
  // clock
  input wire logic aclk,
  // request from the bench: high = release reset
  input wire logic rst_req,
  // shutdown pin of the device
  input wire logic sd_o,
  input wire logic sd_oe_n,
  output logic sd_pin,
  // reset pin toward the device
  output logic reset_in_n
);
  int cnt = 0;
  logic sd_q = 1'b1;
  initial reset_in_n = 1'b0;
  assign sd_pin = sd_oe_n | sd_o;
  // release is delayed, not refused, so a lazy bench cannot break the rule
  always @(posedge aclk) begin
    sd_q <= sd_pin;
    if (sd_q && !sd_pin) cnt <= 0;
    else if (cnt < WAIT_CYC) cnt <= cnt + 1;
    if (!rst_req) reset_in_n <= 1'b0;
    else if (cnt >= WAIT_CYC) reset_in_n <= 1'b1;
  end
endmodule : pfs_ctrl_model

// >>> bench/power_stage_fault_sequencer_test.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  error_cnt++; $display("wrong value %s exp %0h got %0h", n, e, s); end end
module power_stage_fault_sequencer_test;
  localparam int CPM = 10;
  logic aclk = 0, aresetn = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, st;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic t100 = 0, t125 = 0, t155 = 0, gd_ok = 0, cm_ok = 0;
  logic sh_g = 0, sh_s = 0, ovl = 0, ovc = 0, rst_req = 0, rst_n;
  logic sd_o, sd_oe_n, sd_pin, wl_o, wl_oe_n, wh_o, wh_oe_n, ws_o, ws_oe_n;
  logic [3:0] hiz, pd;
  logic rdy;
  int error_cnt = 0, total_checks = 0, t;
  always #4 aclk = ~aclk;

  pfs_sequencer #(.CYC_PER_MS(CPM)) uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .temp_over_100(t100), .temp_over_125(t125), .temp_over_155(t155),
    .gate_drive_supply_ok(gd_ok), .common_supply_ok(cm_ok),
    .short_to_gnd(sh_g), .short_to_stage_supply(sh_s),
    .overload_detect(ovl), .overcurrent_detect(ovc), .reset_in_n(rst_n),
    .shutdown_fault_n_i(sd_pin), .shutdown_fault_n_o(sd_o),
    .shutdown_fault_n_oe_n(sd_oe_n), .temp_warn_low_n_i(wl_oe_n | wl_o),
    .temp_warn_low_n_o(wl_o), .temp_warn_low_n_oe_n(wl_oe_n),
    .temp_warn_high_n_i(wh_oe_n | wh_o), .temp_warn_high_n_o(wh_o),
    .temp_warn_high_n_oe_n(wh_oe_n), .temp_warn_single_n_i(ws_oe_n | ws_o),
    .temp_warn_single_n_o(ws_o), .temp_warn_single_n_oe_n(ws_oe_n),
    .bridge_hiz(hiz), .bridge_pulldown(pd), .ready(rdy));

  pfs_ctrl_model #(.WAIT_CYC(4 * CPM)) u_ctrl (.aclk(aclk), .rst_req(rst_req),
    .sd_o(sd_o), .sd_oe_n(sd_oe_n), .sd_pin(sd_pin), .reset_in_n(rst_n));

  // pin released while the level is below the threshold it reports
  function automatic logic off_exp(input int lvl, input int need);
    return lvl < need;
  endfunction : off_exp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    st = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic wst(input logic [2:0] s);
    do rd(pfs_pkg::STATUS_OFS); while (st[2:0] !== s);
  endtask : wst

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    close_out();
  end

  initial begin
    void'($urandom(55655));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(pfs_pkg::CHECK_OFS);
    `CHK("step", {24'h0, pfs_pkg::CHECK_STEP_MS_RST}, st)
    rd(8'h10);
    `CHK("resp", pfs_pkg::RESP_SLVERR, rsp)
    // two steps of 3 to 5 ms outlast the 4 ms wait so reset rises mid-check
    t = 3 + $urandom % 3;
    wr(pfs_pkg::CHECK_OFS, t);
    wr(pfs_pkg::START_OFS, 32'h3);
    `CHK("bresp", pfs_pkg::RESP_OKAY, rsp)
    rd(pfs_pkg::CHECK_OFS);
    `CHK("step", t, st)
    gd_ok <= 1'b1;
    cm_ok <= 1'b1;
    wst(3'h1);
    `CHK("sd", 1'b0, sd_pin)
    rst_req <= 1'b1;
    wst(3'h2);
    `CHK("sd", 1'b0, sd_pin)
    wst(3'h4);
    repeat (2) @(posedge aclk);
    `CHK("sd", 1'b1, sd_oe_n)
    wst(3'h5);
    repeat (2) @(posedge aclk);
    `CHK("hiz", 4'h0, hiz)
    `CHK("ready", 1'b1, rdy)
    sh_g <= 1'b1;
    repeat (5) @(posedge aclk);
    rd(pfs_pkg::STATUS_OFS);
    `CHK("state", 3'h5, st[2:0])
    sh_g <= 1'b0;
    rst_req <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK("hiz", 4'hF, hiz)
    `CHK("pd", 4'hF, pd)
    `CHK("sd", 1'b1, sd_pin)
    rst_req <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(pfs_pkg::STATUS_OFS);
    `CHK("state", 3'h4, st[2:0])
    wst(3'h5);
    for (int k = 0; k < 2; k++) begin
      {t155, ovl} <= k ? 2'b10 : 2'b01;
      @(posedge aclk);
      {t155, ovl} <= 2'b00;
      repeat (40) @(posedge aclk);
      `CHK("hiz", 4'hF, hiz)
      `CHK("sd", 1'b0, sd_pin)
      rd(pfs_pkg::STATUS_OFS);
      `CHK("latch", 1'b1, st[6-k])
      rst_req <= 1'b0;
      repeat (3) @(posedge aclk);
      `CHK("sd", 1'b1, sd_pin)
      rst_req <= 1'b1;
      wst(3'h5);
      `CHK("latch", 1'b0, st[6-k])
    end
    gd_ok <= 1'b0;
    repeat (4) @(posedge aclk);
    `CHK("hiz", 4'hF, hiz)
    `CHK("sd", 1'b0, sd_pin)
    gd_ok <= 1'b1;
    wst(3'h5);
    repeat (2) @(posedge aclk);
    `CHK("ready", 1'b1, rdy)
    for (int k = 0; k < 2; k++) begin
      wr(pfs_pkg::CONFIG_OFS, k);
      {sh_g, sh_s} <= k ? 2'b01 : 2'b10;
      cm_ok <= 1'b0;
      repeat (3) @(posedge aclk);
      cm_ok <= 1'b1;
      wst(3'h3);
      `CHK("hiz", 4'hF, hiz)
      {sh_g, sh_s} <= 2'b00;
      wst(3'h5);
      `CHK("checked", 1'b1, st[4])
    end
    wr(pfs_pkg::CONFIG_OFS, 32'h2);
    rst_req <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK("pd", 4'h0, pd)
    cm_ok <= 1'b0;
    repeat (3) @(posedge aclk);
    cm_ok <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(pfs_pkg::STATUS_OFS);
    `CHK("state", 3'h4, st[2:0])
    rst_req <= 1'b1;
    wst(3'h5);
    for (int v = 0; v < 2; v++) begin
      wr(pfs_pkg::CONFIG_OFS, v << 2);
      for (int i = 0; i < 12; i++) begin
        t = $urandom % 3;
        t100 <= t > 0;
        t125 <= t > 1;
        repeat (3) @(posedge aclk);
        if (v == 0) begin
          `CHK("warn1", off_exp(t, 1), wl_oe_n | wl_o)
          `CHK("warn2", off_exp(t, 2), wh_oe_n | wh_o)
        end else begin
          `CHK("warn", off_exp(t, 2), ws_oe_n | ws_o)
        end
      end
    end
    {t100, t125} <= 2'b00;
    ovc <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK("ready", 1'b0, rdy)
    ovc <= 1'b0;
    close_out();
  end
endmodule : power_stage_fault_sequencer_test
